// *** pao_pkg.sv ***
// Package with the constants of the pipelined converter output port.
package pao_pkg;
    localparam int          PAO_WIDTH       = 12;
    localparam int          PAO_LATENCY     = 7;
    localparam int          PAO_FIFO_DEPTH  = 8;
    localparam logic [11:0] PAO_CODE_ZERO   = 12'h800;
    localparam logic [11:0] PAO_CODE_POS_FS = 12'hFFF;
    localparam logic [11:0] PAO_CODE_NEG_FS = 12'h000;
    localparam logic [11:0] PAO_RESET_WORD  = 12'h800;
    typedef enum logic [0:0] {
        PAO_RUN,
        PAO_SHUTDOWN
    } pao_mode_t;
endpackage : pao_pkg

// *** pao_stream_if.sv ***
// Interface carrying words between the pipeline and its FIFO.
`timescale 1ns/1ps
interface pao_stream_if #(parameter int WIDTH = 12);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pao_stream_if

// *** pao_fifo.sv ***
// Parameterised FIFO between the conversion pipeline and the output latch.
`timescale 1ns/1ps
module pao_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    pao_stream_if.snk   in_s,
    pao_stream_if.src   out_s
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("pao_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              full   = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire              empty  = (wr_q == rd_q);
    wire              push   = in_s.valid && !full;
    wire              pop    = out_s.ready && !empty;

    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge ref_clk) disable iff (rst)
        in_s.valid |-> !full) else $error("FIFO offered a word while full.");
endmodule : pao_fifo

// *** pao_output_port.sv ***
// Output port of a pipelined converter: latency pipeline, shutdown hold, three-state bus.
`timescale 1ns/1ps
module pao_output_port
    import pao_pkg::*;
#(
    parameter int WIDTH   = PAO_WIDTH,
    parameter int LATENCY = PAO_LATENCY,
    parameter int DEPTH   = PAO_FIFO_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] quantized_code,
    input  wire logic             output_enable_n,
    input  wire logic             shutdown_request,
    output logic      [WIDTH-1:0] sample_word_bus_o,
    output logic      [WIDTH-1:0] sample_word_bus_oe_n,
    output logic                  data_valid_q,
    output logic                  shutdown_active_q
);
    initial begin
        if (WIDTH != PAO_WIDTH || LATENCY < 3 || LATENCY > 14) begin
            $error("pao_output_port: WIDTH must be 12 and LATENCY from 3 to 14");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion pipeline. The sampling register is stage zero and the FIFO and
    // output latch take the last two edges, so the shift register has LATENCY-1 stages.

    localparam int PIPE = LATENCY - 1;

    pao_mode_t        mode_q;
    logic [WIDTH-1:0] pipe_q [PIPE];
    logic [PIPE-1:0]  pv_q;
    logic [WIDTH-1:0] bus_q;
    logic             bus_oe_n_q;
    wire              run = (mode_q == PAO_RUN) && !shutdown_request;

    pao_stream_if #(.WIDTH(WIDTH)) fill_s ();
    pao_stream_if #(.WIDTH(WIDTH)) drain_s ();

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_q <= PAO_RUN;
        end else begin
            mode_q <= shutdown_request ? PAO_SHUTDOWN : PAO_RUN;
        end
    end

    // Input code is already offset binary; it is carried unaltered, bit 0 as LSB.
    always_ff @(posedge ref_clk) begin
        if (run) begin
            pipe_q[0] <= quantized_code;
        end
    end

    for (genvar i = 1; i < PIPE; i++) begin : g_pipe
        always_ff @(posedge ref_clk) begin
            if (run) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pv_q <= '0;
        end else if (run) begin
            pv_q <= {pv_q[PIPE-2:0], 1'b1};
        end
    end

    assign fill_s.valid = run && pv_q[PIPE-1];
    assign fill_s.data  = pipe_q[PIPE-1];

    pao_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .rst     (rst),
        .in_s    (fill_s),
        .out_s   (drain_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output latch. In shutdown the latch stops draining, so the bus keeps the
    // last code and the FIFO holds steady instead of overflowing.

    assign drain_s.ready = run;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_q        <= PAO_RESET_WORD;
            data_valid_q <= 1'b0;
        end else if (drain_s.ready && drain_s.valid) begin
            bus_q        <= drain_s.data;
            data_valid_q <= !output_enable_n;
        end else begin
            data_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_oe_n_q        <= 1'b1;
            shutdown_active_q <= 1'b0;
        end else begin
            bus_oe_n_q        <= output_enable_n;
            shutdown_active_q <= shutdown_request;
        end
    end

    assign sample_word_bus_o    = bus_q;
    assign sample_word_bus_oe_n = {WIDTH{bus_oe_n_q}};

    ////////////////////////////////////////////////////////////////////////////

    // Counts unbroken running edges, so the latency check waits until a full
    // pipeline of fresh samples has passed since reset or shutdown.
    logic [3:0] steady_q;

    always_ff @(posedge ref_clk) begin
        if (rst || !run) begin
            steady_q <= 4'h0;
        end else if (steady_q != 4'hF) begin
            steady_q <= steady_q + 4'h1;
        end
    end

    sequence s_steady_run;
        steady_q >= 4'(LATENCY + 1);
    endsequence

    a_latency_seven: assert property (@(posedge ref_clk) disable iff (rst)
        s_steady_run |-> sample_word_bus_o == $past(quantized_code, LATENCY + 1))
        else $error("Bus word does not match sample taken seven cycles ago.");
    a_enable_floats: assert property (@(posedge ref_clk) disable iff (rst)
        output_enable_n |=> (&sample_word_bus_oe_n))
        else $error("Bus driven while output enable is high.");
    a_enable_drives: assert property (@(posedge ref_clk) disable iff (rst)
        !output_enable_n |=> (sample_word_bus_oe_n == '0))
        else $error("Bus floats while output enable is low.");
    a_shutdown_holds: assert property (@(posedge ref_clk) disable iff (rst)
        shutdown_request |=> $stable(sample_word_bus_o))
        else $error("Bus word changed during shutdown.");
    a_shutdown_mode: assert property (@(posedge ref_clk) disable iff (rst)
        shutdown_request |=> (mode_q == PAO_SHUTDOWN) && !data_valid_q)
        else $error("Shutdown request did not stop conversion.");
endmodule : pao_output_port

// *** pao_capture.sv ***
// Model of the capture logic that registers words from the output bus.
`timescale 1ns/1ps
module pao_capture (
    input  wire logic        ref_clk,
    input  wire logic [11:0] bus,
    input  wire logic        word_valid,
    input  wire logic        drive_n,
    output logic      [11:0] word_q
);
    // Released bus lines carry no data, so nothing is taken while drive_n is high.
    always @(posedge ref_clk) begin
        if (word_valid && !drive_n) word_q <= bus;
    end
endmodule : pao_capture

// *** testbench.sv ***
// Self-checking testbench of the converter output port.
`timescale 1ns/1ps
module testbench;
    import pao_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] code = 12'h000;
    logic        oe_in_n = 1'b0;
    logic        sd = 1'b0;
    logic [11:0] bus_o;
    logic [11:0] bus_oe_n;
    logic        valid;
    logic        sd_act;
    logic [11:0] cap_word;
    wire  [11:0] bus;
    int          num_errors = 0;
    int          checked = 0;
    logic [11:0] pat [8] = '{PAO_CODE_NEG_FS, PAO_CODE_ZERO, PAO_CODE_POS_FS, 12'h001,
                             12'h7FF, 12'h555, 12'hAAA, 12'hFFE};
    ////////////////////////////////////////////////////////////////////////////
    always #5 ref_clk = ~ref_clk;
    for (genvar g = 0; g < 12; g++) begin : g_bus
        assign bus[g] = bus_oe_n[g] ? 1'bz : bus_o[g];
    end
    pao_output_port dut (.ref_clk(ref_clk), .rst(rst), .quantized_code(code),
        .output_enable_n(oe_in_n), .shutdown_request(sd), .sample_word_bus_o(bus_o),
        .sample_word_bus_oe_n(bus_oe_n), .data_valid_q(valid), .shutdown_active_q(sd_act));
    pao_capture cap (.ref_clk(ref_clk), .bus(bus), .word_valid(valid),
        .drive_n(bus_oe_n[0]), .word_q(cap_word));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t bus value %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // Every code reaches the bus seven edges after the edge that took it.
    task automatic t_latency;
        for (int i = 0; i < 16; i++) begin
            @(negedge ref_clk);
            if (i >= 8) begin
                check(bus, pat[(i - 8) % 8]);
                check({11'h000, valid}, 12'h001);
            end
            code = pat[i % 8];
        end
        @(negedge ref_clk);
        check(cap_word, pat[7]);
        $display("latency test done");
    endtask : t_latency
    task automatic t_enable;
        oe_in_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(bus_oe_n, 12'hFFF);
        check(bus, 12'hZZZ);
        check({11'h000, valid}, 12'h000);
        oe_in_n = 1'b0;
        @(negedge ref_clk);
        check(bus_oe_n, 12'h000);
        $display("enable test done");
    endtask : t_enable
    // The input keeps moving during shutdown so a leaky pipeline would show.
    task automatic t_shutdown;
        logic [11:0] held;
        held = bus;
        sd = 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(negedge ref_clk);
            code = pat[i];
            check(bus, held);
            check({11'h000, sd_act}, 12'h001);
        end
        sd = 1'b0;
        @(negedge ref_clk);
        check({11'h000, sd_act}, 12'h000);
        $display("shutdown test done");
    endtask : t_shutdown
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        t_latency();
        t_enable();
        t_shutdown();
        wrap_up();
    end
endmodule : testbench
